// file: pkg/css_pkg.sv
package css_pkg;
  // internal timebase
  localparam int CLK_MHZ          = 125;
  localparam int STEP_NS          = 500;
  localparam int STEP_CYC         = (STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int DEACT_CLK_US     = 12;
  localparam int DEACT_CLK_CYC    = DEACT_CLK_US * CLK_MHZ;
  localparam int RESET_REQUEST_IN_WINDOW_US  = 200;
  localparam int RESET_REQUEST_IN_WINDOW_CYC = RESET_REQUEST_IN_WINDOW_US * CLK_MHZ;
  localparam int DEBOUNCE_MS      = 8;
  localparam int DEBOUNCE_CYC     = DEBOUNCE_MS * 1000 * CLK_MHZ;
  localparam int POR_MS           = 8;
  localparam int POR_CYC          = POR_MS * 1000 * CLK_MHZ;
  localparam int CNT_W            = 24;
  // card clock ratio select encodings {hi,lo}
  localparam logic [1:0] RATIO_DIV8 = 2'h0;
  localparam logic [1:0] RATIO_DIV4 = 2'h1;
  localparam logic [1:0] RATIO_DIV1 = 2'h2;
  localparam logic [1:0] RATIO_DIV2 = 2'h3;

  typedef enum logic [3:0] {
    CSS_POR, CSS_STANDBY, CSS_SUPPLY_UP, CSS_IO_ON, CSS_CLK_ON, CSS_ACTIVE,
    CSS_DEACT_RST, CSS_DEACT_CLK, CSS_DEACT_IO, CSS_DEACT_SUPPLY
  } css_state_t;
endpackage

// file: src/css_sequencer.sv
`timescale 1ns/10ps
module css_sequencer
  import css_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int POR_CYCLES      = POR_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic source_clock_in_i,
  input  wire logic clk_ratio_sel_hi_i,
  input  wire logic clk_ratio_sel_lo_i,
  input  wire logic session_cmd_n_i,
  input  wire logic reset_request_in_i,
  input  wire logic card_detect_in_i,
  input  wire logic undervoltage_lockout_i,
  input  wire logic regulator_input_supply_low_i,
  input  wire logic card_supply_ok_i,
  input  wire logic card_supply_fault_i,
  input  wire logic overtemp_i,
  input  wire logic pin_short_i,
  output logic      card_supply_en_o,
  output logic      card_io_en_o,
  output logic      card_aux_en_o,
  output logic      card_clock_out_o,
  output logic      card_reset_out_o,
  output logic      pin_current_limit_o,
  output logic      int_n_o
);

  // two-flop synchronisers: index 0 first stage, 1 second stage; ratio select goes through s_sel_meta then s_sel
  typedef struct packed {
    logic [1:0]  s_cmd_n;
    logic [1:0]  s_reset_request_in;
    logic [1:0]  s_card_detect_in;
    logic [1:0]  s_undervoltage_lockout;
    logic [1:0]  s_regulator_input_supply;
    logic [1:0]  s_vok;
    logic [1:0]  s_vflt;
    logic [1:0]  s_otp;
    logic [1:0]  s_short;
    logic [1:0]  s_srcclk;
    logic [1:0]  s_sel_meta;
    logic [1:0]  s_sel;
    logic        cmd_prev;
    logic        reset_request_in_prev;
    logic        src_prev;
    css_state_t  st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] win;
    logic [CNT_W-1:0] deb;
    logic        card_ok;
    logic        reset_request_in_mode;
    logic        clk_run;
    logic [2:0]  div;
    logic        card_clock_out;
    logic        vcc;
    logic        io;
    logic        card_reset_out;
    logic        ilim;
    logic        int_n;
  } css_regs_t;

  css_regs_t r;
  css_regs_t next_r;

  // source rising edges per card clock half period, less one
  function automatic logic [2:0] half_div(input logic [1:0] sel);
    unique case (sel)
      RATIO_DIV8: half_div = 3'h3;
      RATIO_DIV4: half_div = 3'h1;
      RATIO_DIV2: half_div = 3'h0;
      RATIO_DIV1: half_div = 3'h0;
    endcase
  endfunction

  // ratio select asks for the undivided source clock
  function automatic logic is_div_one(input logic [1:0] sel);
    is_div_one = (sel == RATIO_DIV1);
  endfunction

  // controlled-clock window still open; the timer saturates at its end
  function automatic logic window_open(input logic [CNT_W-1:0] w);
    window_open = (w != CNT_W'(RESET_REQUEST_IN_WINDOW_CYC));
  endfunction

  logic fault;
  logic src_rise;
  logic src_fall;
  logic start_req;
  logic reset_request_in_fall;

  // fault summary; pin short is deliberately excluded
  always_comb begin
    fault = !r.s_card_detect_in[1] || r.s_undervoltage_lockout[1] || r.s_vflt[1] || r.s_regulator_input_supply[1]
            || r.s_otp[1];
    src_rise = r.s_srcclk[1] && !r.src_prev;
    src_fall = !r.s_srcclk[1] && r.src_prev;
    start_req = r.cmd_prev && !r.s_cmd_n[1];
    reset_request_in_fall = r.reset_request_in_prev && !r.s_reset_request_in[1];
  end

  // next-state logic
  always_comb begin
    next_r = r;
    next_r.s_cmd_n  = {r.s_cmd_n[0], session_cmd_n_i};
    next_r.s_reset_request_in  = {r.s_reset_request_in[0], reset_request_in_i};
    next_r.s_card_detect_in   = {r.s_card_detect_in[0], card_detect_in_i};
    next_r.s_undervoltage_lockout   = {r.s_undervoltage_lockout[0], undervoltage_lockout_i};
    next_r.s_regulator_input_supply   = {r.s_regulator_input_supply[0], regulator_input_supply_low_i};
    next_r.s_vok    = {r.s_vok[0], card_supply_ok_i};
    next_r.s_vflt   = {r.s_vflt[0], card_supply_fault_i};
    next_r.s_otp    = {r.s_otp[0], overtemp_i};
    next_r.s_short  = {r.s_short[0], pin_short_i};
    next_r.s_srcclk = {r.s_srcclk[0], source_clock_in_i};
    next_r.s_sel_meta = {clk_ratio_sel_hi_i, clk_ratio_sel_lo_i};
    next_r.s_sel      = r.s_sel_meta;
    next_r.cmd_prev   = r.s_cmd_n[1];
    next_r.reset_request_in_prev = r.s_reset_request_in[1];
    next_r.src_prev   = r.s_srcclk[1];
    next_r.ilim = r.s_short[1];

    // insertion debounce, removal clears at once
    if (!r.s_card_detect_in[1]) begin
      next_r.deb = '0;
      next_r.card_ok = 1'b0;
    end else if (!r.card_ok) begin
      if (r.deb == CNT_W'(DEBOUNCE_CYCLES - 1)) begin
        next_r.card_ok = 1'b1;
      end else begin
        next_r.deb = r.deb + 1'b1;
      end
    end

    // controlled-clock window timer from session start
    if (window_open(r.win)) begin
      next_r.win = r.win + 1'b1;
    end

    // card clock divider, 50% duty for divided ratios
    // a ratio change mid-run may stretch one phase before it settles
    if (!r.clk_run) begin
      next_r.card_clock_out = 1'b0;
      next_r.div = '0;
    end else if (is_div_one(r.s_sel)) begin
      next_r.card_clock_out = r.s_srcclk[1];
    end else if (src_rise) begin
      if (r.div == half_div(r.s_sel)) begin
        next_r.div = '0;
        next_r.card_clock_out = !r.card_clock_out;
      end else begin
        next_r.div = r.div + 1'b1;
      end
    end
    if (src_fall && is_div_one(r.s_sel)) begin
      next_r.card_clock_out = 1'b0;
    end

    // shared step counter; each timed state clears it on entry
    next_r.cnt = r.cnt + 1'b1;

    // session sequencing
    unique case (r.st)
      CSS_POR: begin
        next_r.int_n = 1'b0;
        if (r.cnt == CNT_W'(POR_CYCLES - 1)) begin
          next_r.st = CSS_STANDBY;
        end
      end
      CSS_STANDBY: begin
        next_r.vcc = 1'b0;
        next_r.io = 1'b0;
        next_r.card_reset_out = 1'b0;
        next_r.clk_run = 1'b0;
        // presence indication, dropped under host undervoltage
        next_r.int_n = r.card_ok && !r.s_undervoltage_lockout[1];
        // a start without a settled card, or with a fault, is ignored
        if (start_req && r.card_ok && !fault) begin
          next_r.reset_request_in_mode = r.s_reset_request_in[1];
          next_r.win = '0;
          next_r.vcc = 1'b1;
          next_r.st = CSS_SUPPLY_UP;
        end
      end
      CSS_SUPPLY_UP: begin
        // card signals stay low until supply is good
        if (r.s_vok[1]) begin
          next_r.io = 1'b1;
          next_r.cnt = '0;
          next_r.st = CSS_IO_ON;
        end
      end
      CSS_IO_ON: begin
        if (r.reset_request_in_mode) begin
          // clock starts on the falling edge of reset request
          if (reset_request_in_fall && window_open(r.win)) begin
            next_r.clk_run = 1'b1;
          end
          if (!window_open(r.win)) begin
            next_r.clk_run = 1'b1;
            next_r.st = CSS_ACTIVE;
          end
        end else if (r.cnt == CNT_W'(STEP_CYC - 1)) begin
          next_r.clk_run = 1'b1;
          next_r.cnt = '0;
          next_r.st = CSS_CLK_ON;
        end
      end
      CSS_CLK_ON: begin
        // second step before the reset path opens
        if (r.cnt == CNT_W'(STEP_CYC - 1)) begin
          next_r.st = CSS_ACTIVE;
        end
      end
      CSS_ACTIVE: begin
        // card reset now follows the request level
        next_r.card_reset_out = r.s_reset_request_in[1];
      end
      CSS_DEACT_RST: begin
        // reset held low while the clock runs out its delay
        next_r.card_reset_out = 1'b0;
        if (r.cnt == CNT_W'(DEACT_CLK_CYC - 1)) begin
          next_r.clk_run = 1'b0;
          next_r.st = CSS_DEACT_CLK;
        end
      end
      CSS_DEACT_CLK: begin
        next_r.io = 1'b0;
        next_r.st = CSS_DEACT_IO;
      end
      CSS_DEACT_IO: begin
        next_r.vcc = 1'b0;
        next_r.st = CSS_DEACT_SUPPLY;
      end
      CSS_DEACT_SUPPLY: begin
        // hold until host releases the command
        if (r.s_cmd_n[1]) begin
          next_r.st = CSS_STANDBY;
        end
      end
    endcase

    // session end by host or by fault
    if (r.st inside {CSS_SUPPLY_UP, CSS_IO_ON, CSS_CLK_ON, CSS_ACTIVE}) begin
      if (fault) begin
        next_r.int_n = 1'b0;
      end
      if (fault || r.s_cmd_n[1]) begin
        next_r.card_reset_out = 1'b0;
        next_r.cnt = '0;
        next_r.st = CSS_DEACT_RST;
      end
    end

    // a fault or removal while shutting down still drops the interrupt
    if (r.st inside {CSS_DEACT_RST, CSS_DEACT_CLK, CSS_DEACT_IO, CSS_DEACT_SUPPLY}) begin
      if (fault) begin
        next_r.int_n = 1'b0;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '{s_cmd_n: 2'h3, cmd_prev: 1'b1, st: CSS_POR, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // outputs come straight from the state register
  assign card_supply_en_o    = r.vcc;
  assign card_io_en_o        = r.io;
  assign card_aux_en_o       = r.io;
  assign card_clock_out_o    = r.card_clock_out;
  assign card_reset_out_o    = r.card_reset_out;
  assign pin_current_limit_o = r.ilim;
  assign int_n_o             = r.int_n;

endmodule

// file: dv/css_sequencer_sva.sv
`timescale 1ns/10ps
module css_sequencer_sva (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic card_detect_in_i,
  input wire logic undervoltage_lockout_i,
  input wire logic pin_short_i,
  input wire logic card_supply_en_o,
  input wire logic card_io_en_o,
  input wire logic card_clock_out_o,
  input wire logic card_reset_out_o,
  input wire logic pin_current_limit_o,
  input wire logic int_n_o
);
  // sequencing, current limit and interrupt relations, all on the timebase
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_io_needs_supply: assert property (card_io_en_o |-> card_supply_en_o)
    else $error("lines on without supply");
  a_clock_needs_io: assert property (card_clock_out_o |-> card_io_en_o)
    else $error("clock without lines");
  a_reset_needs_io: assert property (card_reset_out_o |-> card_io_en_o)
    else $error("reset without lines");
  a_reset_leads: assert property ($fell(card_reset_out_o) |=> card_io_en_o [*8])
    else $error("lines dropped with reset");
  a_supply_last: assert property ($fell(card_io_en_o) |=> !card_supply_en_o)
    else $error("supply not off after lines");
  a_limit_lag: assert property ($rose(pin_short_i) |-> ##[2:4] pin_current_limit_o)
    else $error("no current limit on short");
  a_removal_int: assert property ($fell(card_detect_in_i) |-> ##[1:4] !int_n_o)
    else $error("interrupt high after removal");
  a_uv_int: assert property ($rose(undervoltage_lockout_i) |-> ##[1:4] !int_n_o)
    else $error("interrupt high in undervoltage");
endmodule

bind css_sequencer css_sequencer_sva u_sva (.*);

// file: dv/css_host_model.sv
`timescale 1ns/10ps
module css_host_model (
  input  wire logic clk_i,
  input  wire logic int_n_i,
  output logic      session_cmd_n_o,
  output logic      reset_request_o
);
  // idle host: session closed, no reset request
  initial begin
    session_cmd_n_o = 1'b1;
    reset_request_o = 1'b0;
  end
  // pick the clock mode first, then open only if a card shows (blind skips that)
  task automatic open_session(input logic ctrl, input logic blind);
    logic seen;
    @(posedge clk_i);
    reset_request_o <= ctrl;
    @(negedge clk_i);
    seen = int_n_i;
    @(posedge clk_i);
    if (blind || seen === 1'b1) session_cmd_n_o <= 1'b0;
  endtask
  // reset request level, which also starts the clock in controlled mode
  task automatic set_req(input logic v);
    @(posedge clk_i);
    reset_request_o <= v;
  endtask
  // ends a session, also the answer to a fault shutdown
  task automatic close_session();
    @(posedge clk_i);
    session_cmd_n_o <= 1'b1;
  endtask
endmodule

// file: dv/testbench.sv
`timescale 1ns/10ps
module testbench;
  import css_pkg::*;
  localparam int PC = 50;
  logic       clk_i, rst_n_i, source_clock_in_i, clk_ratio_sel_hi_i, clk_ratio_sel_lo_i;
  logic       pin_short_i, card_supply_ok_i, card_supply_en_o, card_io_en_o, card_aux_en_o;
  logic       card_clock_out_o, card_reset_out_o, pin_current_limit_o, int_n_o;
  wire        session_cmd_n_i, reset_request_in_i, card_detect_in_i, undervoltage_lockout_i;
  wire        regulator_input_supply_low_i, card_supply_fault_i, overtemp_i;
  logic [4:0] flt;
  logic [7:0] ramp;
  logic [1:0] sc;
  logic [6:0] obs;
  int         error_cnt, tests_run, t0;
  int         half[4] = '{32, 16, 4, 8};
  assign {card_detect_in_i, undervoltage_lockout_i, regulator_input_supply_low_i,
          card_supply_fault_i, overtemp_i} = flt;
  css_sequencer #(.DEBOUNCE_CYCLES(PC), .POR_CYCLES(2 * PC)) dut (.*);
  css_host_model host (.clk_i(clk_i), .int_n_i(int_n_o), .session_cmd_n_o(session_cmd_n_i),
                       .reset_request_o(reset_request_in_i));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // source clock at an eighth of the timebase; supply settles after enable
  always @(posedge clk_i) begin
    ramp <= {ramp[6:0], card_supply_en_o & ~card_supply_fault_i};
    card_supply_ok_i <= ramp[6];
    sc <= sc + 2'h1;
    if (sc == 2'h3) source_clock_in_i <= ~source_clock_in_i;
  end
  // settled copy of the outputs, taken mid-cycle
  always @(negedge clk_i) obs <= {card_aux_en_o, int_n_o, pin_current_limit_o,
                                  card_reset_out_o, card_clock_out_o, card_io_en_o,
                                  card_supply_en_o};
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // bounded wait for output bit w to read v, cycles waited in t0
  task automatic wait_obs(input int w, input logic v);
    for (t0 = 0; t0 < 30000 && obs[w] !== v; t0++) @(posedge clk_i);
    if (obs[w] !== v) begin
      chk("wait_obs", obs[w], v);
      complete_run();
    end
  endtask
  // reset first, lines after the long step, supply one cycle later
  task automatic deact();
    wait_obs(3, 1'b0);
    wait_obs(1, 1'b0);
    chk("io_off", t0 inside {[DEACT_CLK_CYC - 8 : DEACT_CLK_CYC + 2]}, 1'b1);
    chk("aux_off", obs[6], 1'b0);
    wait_obs(0, 1'b0);
    chk("sup_off", t0, 1);
  endtask
  task automatic t_standby();
    chk("idle_out", obs[3:0], 4'h0);
    host.open_session(1'b0, 1'b1);
    cyc(20);
    chk("no_card", obs, 7'h00);
    host.close_session();
    flt <= 5'h10;
    cyc(PC / 2);
    chk("int_bounce", obs[5], 1'b0);
    cyc(PC);
    chk("int_card", obs[5], 1'b1);
    flt <= 5'h18;
    cyc(4);
    chk("int_uv", obs[5], 1'b0);
    flt <= 5'h10;
    pin_short_i <= 1'b1;
    cyc(8);
    chk("int_short", obs[5:4], 2'h3);
    pin_short_i <= 1'b0;
    $display("standby test done");
  endtask
  task automatic t_normal();
    host.open_session(1'b0, 1'b0);
    wait_obs(0, 1'b1);
    cyc(3);
    chk("io_ramp", obs[1], 1'b0);
    wait_obs(1, 1'b1);
    chk("aux_on", obs[6], 1'b1);
    wait_obs(2, 1'b1);
    chk("clk_gap", t0 inside {[STEP_CYC : STEP_CYC + 12]}, 1'b1);
    host.set_req(1'b1);
    cyc(STEP_CYC - 12);
    chk("rst_early", obs[3], 1'b0);
    cyc(20);
    chk("rst_on", obs[3], 1'b1);
    for (int r = 0; r < 4; r++) begin
      {clk_ratio_sel_hi_i, clk_ratio_sel_lo_i} <= r[1:0];
      cyc(80);
      wait_obs(2, 1'b1);
      wait_obs(2, 1'b0);
      wait_obs(2, 1'b1);
      chk("half_period", t0, half[r]);
    end
    host.close_session();
    deact();
    $display("normal test done");
  endtask
  task automatic t_ctrl();
    host.open_session(1'b1, 1'b0);
    wait_obs(1, 1'b1);
    cyc(200);
    chk("clk_held", obs[2], 1'b0);
    host.set_req(1'b0);
    wait_obs(2, 1'b1);
    chk("clk_at_fall", t0 <= 16, 1'b1);
    host.set_req(1'b1);
    cyc(RESET_REQUEST_IN_WINDOW_CYC - 1000);
    chk("rst_window", obs[3], 1'b0);
    cyc(1200);
    chk("rst_mirror", obs[3], 1'b1);
    host.set_req(1'b0);
    cyc(8);
    chk("rst_follow", obs[3], 1'b0);
    wait_obs(2, 1'b1);
    wait_obs(2, 1'b0);
    wait_obs(2, 1'b1);
    chk("clk_kept", t0, half[3]);
    host.set_req(1'b1);
    cyc(8);
    host.close_session();
    deact();
    $display("controlled clock test done");
  endtask
  // each fault in turn, card removal last
  task automatic t_fault();
    for (int f = 0; f < 5; f++) begin
      host.open_session(1'b0, 1'b0);
      wait_obs(2, 1'b1);
      flt <= 5'h10 ^ (5'h01 << f);
      cyc(6);
      chk("int_fault", obs[5], 1'b0);
      deact();
      host.close_session();
      flt <= 5'h10;
      cyc(PC + 20);
      chk("int_after", obs[5], 1'b1);
    end
    $display("fault test done");
  endtask
  // mid-run reset: interrupt held low through the power-on pulse
  task automatic t_por();
    rst_n_i <= 1'b0;
    cyc(2);
    rst_n_i <= 1'b1;
    cyc(PC + 20);
    chk("por_int", obs, 7'h00);
    cyc(PC);
    chk("por_done", obs[5], 1'b1);
    $display("power-on reset test done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    {rst_n_i, source_clock_in_i, sc, ramp, card_supply_ok_i, pin_short_i, flt} = '0;
    {clk_ratio_sel_hi_i, clk_ratio_sel_lo_i} = 2'h2;
    error_cnt = 0;
    tests_run = 0;
    cyc(20);
    rst_n_i <= 1'b1;
    cyc(2 * PC + 10);
    t_standby();
    t_normal();
    t_ctrl();
    t_fault();
    t_por();
    complete_run();
  end
  // watchdog at about twice the expected run length
  initial begin
    cyc(80000);
    error_cnt++;
    complete_run();
  end
endmodule
